/* rtl/crp_cfg.svh */
// Purpose: Constants of the CRC-protected register port
// Assumes: Byte offsets as seen on the serial link
// Notes:   Included by the port module only
`ifndef CRP_CFG_SVH
`define CRP_CFG_SVH

`define CRP_BUS_ADDR    7'h6D
`define CRP_OFS_CMD     8'h22
`define CRP_OFS_TEMP    8'h2E
`define CRP_OFS_PRESS   8'h30
`define CRP_OFS_SYNC    8'h32
`define CRP_OFS_STATUS  8'h36
`define CRP_CMD_SLEEP   16'h6C32
`define CRP_CMD_RESET   16'hB169
`define CRP_HEADER_CHECK_NIBBLE_POLY   4'h3
`define CRP_HEADER_CHECK_NIBBLE_INIT   4'hF
`define CRP_FRAME_CHECK_BYTE_POLY   8'hD5
`define CRP_FRAME_CHECK_BYTE_INIT   8'hFF
`define CRP_BIT_CRCERR  4'hB
`define CRP_MAX_WR_LEN  4'h3
`define CRP_BYTE_BITS   4'h8
`define CRP_IDLE_BYTE   8'hFF

`endif

/* rtl/crp_pkg.sv */
// Purpose: Types of the CRC-protected register port
// Assumes: Nothing beyond the constants header
// Notes:   One packed struct carries all state
package crp_pkg;

   typedef enum logic [2:0]
   {
      PH_IDLE  = 3'b000,
      PH_RX    = 3'b001,
      PH_ACK   = 3'b010,
      PH_TX    = 3'b011,
      PH_TXACK = 3'b100
   } crp_phase_type;

   typedef enum logic [2:0]
   {
      FR_ADDR  = 3'b000,
      FR_MEM   = 3'b001,
      FR_LEN   = 3'b010,
      FR_WDATA = 3'b011,
      FR_WCRC  = 3'b100,
      FR_READ  = 3'b101,
      FR_IGN   = 3'b110
   } crp_frame_type;

   typedef enum logic [1:0]
   {
      SQ_RUN   = 2'b00,
      SQ_LOAD  = 2'b01,
      SQ_CHECK = 2'b10
   } crp_seq_type;

   typedef struct packed
   {
      crp_phase_type phase;
      crp_frame_type frm;
      crp_seq_type   seq;
      logic          scl_q;
      logic          sda_q;
      logic [3:0]    bitc;
      logic [7:0]    shreg;
      logic          oe;
      logic          mack;
      logic [3:0]    header_check_nibble;
      logic [7:0]    frame_check_byte;
      logic [7:0]    mem;
      logic [3:0]    len;
      logic          hdr_ok;
      logic [4:0]    bytec;
      logic [31:0]   wbuf;
      logic [15:0]   status;
      logic          sleep;
   } crp_state_type;

endpackage

/* rtl/crp_port.sv */
// Purpose: Serial register port with header and frame checks
// Assumes: scl and sda_in are synchronous to sys_clk
// Notes:   Open-drain sda: sda_oe high pulls the line low
//
// Functional notes
// - Protected frames use bus address 0x6D.
// - Read: header, restart, data low first, check.
// - Write: header, data low first, check byte.
// - Status word write clears the selected events.
// - Only status and command are writable.
// - Command register 16-bit, write-only, default zero.
// - Sleep code powers down conditioning circuitry.
// - Reset code reloads registers from configuration memory.
// - Reload is followed by a configuration CRC check.
// - Length nibble is bytes minus one, odd.
// - Header nibble: polynomial 0x03, start 0x0F.
// - Frame byte: polynomial 0xD5, start 0xFF.
// - Check mismatch sets the communication error event.
`timescale 1ns/100ps
`include "crp_cfg.svh"

module crp_port
(
   input  wire logic        sys_clk,        // System clock, 40 MHz
   input  wire logic        rst_n,          // Asynchronous reset, active low
   input  wire logic        scl,            // Serial clock level
   input  wire logic        sda_in,         // Serial data level
   output wire logic        sda_out,        // Serial data drive value
   output wire logic        sda_oe,         // Serial data pull-low enable
   input  wire logic [15:0] evt_set,        // Event pulses into status
   input  wire logic [15:0] lvl_in,         // Level status bits
   input  wire logic [15:0] temp_in,        // Temperature word
   input  wire logic [15:0] press_in,       // Pressure word
   input  wire logic        cfg_load_done,  // Configuration load finished
   input  wire logic        cfg_check_done, // Configuration check finished
   output wire logic        sleep_mode,     // Conditioning powered down
   output wire logic        cfg_load_req,   // Load configuration memory
   output wire logic        cfg_check_req   // Check loaded configuration
);

   crp_pkg::crp_state_type r;
   crp_pkg::crp_state_type next_r;

   function automatic logic [3:0] header_check_nibble_step(input logic [3:0] c, input logic d);
      header_check_nibble_step = {c[2:0], 1'b0} ^ ((c[3] ^ d) ? `CRP_HEADER_CHECK_NIBBLE_POLY : 4'h0);
   endfunction

   function automatic logic [7:0] frame_check_byte_step(input logic [7:0] c, input logic d);
      frame_check_byte_step = {c[6:0], 1'b0} ^ ((c[7] ^ d) ? `CRP_FRAME_CHECK_BYTE_POLY : 8'h00);
   endfunction

   function automatic logic [15:0] read_word(input crp_pkg::crp_state_type s,
                                             input logic [7:0] a);
      if (a == `CRP_OFS_TEMP)
         read_word = temp_in;
      else if (a == `CRP_OFS_PRESS)
         read_word = press_in;
      else if (a == `CRP_OFS_SYNC || a == `CRP_OFS_STATUS)
         read_word = s.status | lvl_in;
      else
         read_word = 16'h0000;
   endfunction

   // Data bytes low first, then the running frame check, then filler
   function automatic logic [7:0] read_byte(input crp_pkg::crp_state_type s);
      logic [15:0] w;
      w = read_word(s, s.mem + {3'h0, s.bytec[4:1], 1'b0});
      if (s.bytec <= {1'b0, s.len})
         read_byte = s.bytec[0] ? w[15:8] : w[7:0];
      else if (s.bytec == {1'b0, s.len} + 5'h01)
         read_byte = s.frame_check_byte;
      else
         read_byte = `CRP_IDLE_BYTE;
   endfunction

   always_comb
   begin
      logic        rise, fall, start, stop;
      logic        ack, crc_err, go_sleep, go_reset;
      logic [15:0] clr, w;
      logic [7:0]  a, b;
      rise     = scl && !r.scl_q;
      fall     = !scl && r.scl_q;
      start    = scl && r.scl_q && r.sda_q && !sda_in;
      stop     = scl && r.scl_q && !r.sda_q && sda_in;
      ack      = 1'b0;
      crc_err  = 1'b0;
      go_sleep = 1'b0;
      go_reset = 1'b0;
      clr      = 16'h0000;
      w        = 16'h0000;
      a        = 8'h00;
      b        = r.shreg;
      next_r   = r;
      next_r.scl_q = scl;
      next_r.sda_q = sda_in;

      if (start)
      begin
         next_r.phase = crp_pkg::PH_RX;
         next_r.frm   = crp_pkg::FR_ADDR;
         next_r.bitc  = 4'h0;
         next_r.oe    = 1'b0;
         next_r.header_check_nibble  = `CRP_HEADER_CHECK_NIBBLE_INIT;
         if (r.phase == crp_pkg::PH_IDLE)
            next_r.frame_check_byte = `CRP_FRAME_CHECK_BYTE_INIT;
      end
      else if (stop)
      begin
         next_r.phase = crp_pkg::PH_IDLE;
         next_r.oe    = 1'b0;
      end
      else if (rise)
      begin
         case (r.phase)
            crp_pkg::PH_RX:
            begin
               next_r.shreg = {r.shreg[6:0], sda_in};
               next_r.bitc  = r.bitc + 4'h1;
               if (r.frm == crp_pkg::FR_MEM || r.frm == crp_pkg::FR_LEN)
                  next_r.header_check_nibble = header_check_nibble_step(r.header_check_nibble, sda_in);
            end
            crp_pkg::PH_TX:
               next_r.frame_check_byte = frame_check_byte_step(r.frame_check_byte, sda_in);
            crp_pkg::PH_TXACK:
               next_r.mack = !sda_in;
            default:
               next_r.mack = r.mack;
         endcase
      end
      else if (fall)
      begin
         case (r.phase)
            crp_pkg::PH_RX:
            begin
               // Commit a bit at its falling edge: a repeated start leaves no stray bit
               if (r.bitc != 4'h0)
                  next_r.frame_check_byte = frame_check_byte_step(r.frame_check_byte, r.shreg[0]);
               if (r.bitc == `CRP_BYTE_BITS)
               begin
                  case (r.frm)
                     crp_pkg::FR_ADDR:
                     begin
                        if (b[7:1] == `CRP_BUS_ADDR && !b[0])
                        begin
                           ack        = 1'b1;
                           next_r.frm = crp_pkg::FR_MEM;
                        end
                        else if (b[7:1] == `CRP_BUS_ADDR && r.hdr_ok)
                        begin
                           ack          = 1'b1;
                           next_r.frm   = crp_pkg::FR_READ;
                           next_r.bytec = 5'h00;
                        end
                        else
                           next_r.frm = crp_pkg::FR_IGN;
                     end
                     crp_pkg::FR_MEM:
                     begin
                        ack        = 1'b1;
                        next_r.mem = b;
                        next_r.frm = crp_pkg::FR_LEN;
                     end
                     crp_pkg::FR_LEN:
                     begin
                        crc_err       = (r.header_check_nibble != 4'h0);
                        next_r.len    = b[7:4];
                        next_r.hdr_ok = !crc_err && b[4] && !r.mem[0];
                        ack           = next_r.hdr_ok;
                        next_r.bytec  = 5'h00;
                        next_r.frm    = crp_pkg::FR_WDATA;
                     end
                     crp_pkg::FR_WDATA:
                     begin
                        if (r.hdr_ok && r.len <= `CRP_MAX_WR_LEN)
                        begin
                           ack = 1'b1;
                           next_r.wbuf[{r.bytec[1:0], 3'b000} +: 8] = b;
                           next_r.bytec = r.bytec + 5'h01;
                           if (r.bytec == {1'b0, r.len})
                              next_r.frm = crp_pkg::FR_WCRC;
                        end
                        else
                           next_r.frm = crp_pkg::FR_IGN;
                     end
                     crp_pkg::FR_WCRC:
                     begin
                        ack        = 1'b1;
                        next_r.frm = crp_pkg::FR_IGN;
                        if (next_r.frame_check_byte != 8'h00)
                           crc_err = 1'b1;
                        else
                        begin
                           for (int i = 0; i < 2; i++)
                           begin
                              if (i == 0 || r.len[1])
                              begin
                                 a = r.mem + 8'(2 * i);
                                 w = r.wbuf[16 * i +: 16];
                                 if (a == `CRP_OFS_STATUS)
                                    clr = clr | w;
                                 else if (a == `CRP_OFS_CMD)
                                 begin
                                    if (w == `CRP_CMD_SLEEP)
                                       go_sleep = 1'b1;
                                    else if (w == `CRP_CMD_RESET)
                                       go_reset = 1'b1;
                                 end
                              end
                           end
                        end
                     end
                     default:
                        ack = 1'b0;
                  endcase
                  next_r.oe    = ack;
                  next_r.phase = crp_pkg::PH_ACK;
               end
            end
            crp_pkg::PH_ACK, crp_pkg::PH_TXACK:
            begin
               next_r.oe    = 1'b0;
               next_r.bitc  = 4'h0;
               next_r.phase = (r.phase == crp_pkg::PH_ACK) ? crp_pkg::PH_RX : crp_pkg::PH_IDLE;
               if (r.frm == crp_pkg::FR_READ && (r.phase == crp_pkg::PH_ACK || r.mack))
               begin
                  b            = read_byte(r);
                  next_r.oe    = !b[7];
                  next_r.shreg = {b[6:0], 1'b0};
                  next_r.bitc  = 4'h1;
                  next_r.bytec = r.bytec + 5'h01;
                  next_r.phase = crp_pkg::PH_TX;
               end
            end
            crp_pkg::PH_TX:
            begin
               if (r.bitc == `CRP_BYTE_BITS)
               begin
                  next_r.oe    = 1'b0;
                  next_r.phase = crp_pkg::PH_TXACK;
               end
               else
               begin
                  next_r.oe    = !r.shreg[7];
                  next_r.shreg = {r.shreg[6:0], 1'b0};
                  next_r.bitc  = r.bitc + 4'h1;
               end
            end
            default:
               next_r.oe = 1'b0;
         endcase
      end

      // Event set wins over a clear in the same cycle
      next_r.status = (r.status & ~clr) | evt_set;
      next_r.status[`CRP_BIT_CRCERR] = next_r.status[`CRP_BIT_CRCERR] | crc_err;

      case (r.seq)
         crp_pkg::SQ_LOAD:
            if (cfg_load_done)
               next_r.seq = crp_pkg::SQ_CHECK;
         crp_pkg::SQ_CHECK:
            if (cfg_check_done)
               next_r.seq = crp_pkg::SQ_RUN;
         default:
            next_r.seq = crp_pkg::SQ_RUN;
      endcase
      if (go_sleep)
         next_r.sleep = 1'b1;
      if (go_reset)
      begin
         next_r.seq    = crp_pkg::SQ_LOAD;
         next_r.sleep  = 1'b0;
         next_r.hdr_ok = 1'b0;
         next_r.status = 16'h0000;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r       <= '0;
         r.scl_q <= 1'b1;
         r.sda_q <= 1'b1;
      end
      else
         r <= next_r;
   end

   assign sda_out       = 1'b0;
   assign sda_oe        = r.oe;
   assign sleep_mode    = r.sleep;
   assign cfg_load_req  = (r.seq == crp_pkg::SQ_LOAD);
   assign cfg_check_req = (r.seq == crp_pkg::SQ_CHECK);

endmodule

/* test/crp_port_checker.sv */
// Purpose: Port checks of crp_port
// Assumes: Sees the top ports only
// Notes:   Bound after the module
`timescale 1ns/100ps
module crp_port_checker
(
   input wire logic        sys_clk,        // Clock
   input wire logic        rst_n,          // Reset
   input wire logic        scl,            // Bus clock
   input wire logic        sda_in,         // Line
   input wire logic        sda_out,        // Drive value
   input wire logic        sda_oe,         // Pull low
   input wire logic [15:0] evt_set,        // Events
   input wire logic [15:0] lvl_in,         // Levels
   input wire logic [15:0] temp_in,        // Temperature
   input wire logic [15:0] press_in,       // Pressure
   input wire logic        cfg_load_done,  // Load end
   input wire logic        cfg_check_done, // Check end
   input wire logic        sleep_mode,     // Sleep
   input wire logic        cfg_load_req,   // Load step
   input wire logic        cfg_check_req   // Check step
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl)
      else $error("sda_oe moved with scl high");
   oe_stands_a: assert property ($rose(sda_oe) |-> sda_oe [*5])
      else $error("sda_oe pulse too short");
   load_hold_a: assert property (cfg_load_req && !cfg_load_done |=> cfg_load_req)
      else $error("load step dropped early");
   check_hold_a: assert property (cfg_check_req && !cfg_check_done |=> cfg_check_req)
      else $error("check step dropped early");
   step_excl_a: assert property (!(cfg_load_req && cfg_check_req))
      else $error("load and check together");
   check_order_a: assert property ($rose(cfg_check_req) |-> $past(cfg_load_req))
      else $error("check step without load");
   sleep_exit_a: assert property ($fell(sleep_mode) |-> cfg_load_req)
      else $error("sleep left without reset");
   sleep_commit_a: assert property ($rose(sleep_mode) |-> ##[0:24] $fell(sda_oe))
      else $error("sleep outside a frame end");
endmodule

bind crp_port crp_port_checker u_crp_port_checker
(
   .sys_clk(sys_clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .evt_set(evt_set), .lvl_in(lvl_in), .temp_in(temp_in),
   .press_in(press_in), .cfg_load_done(cfg_load_done), .cfg_check_done(cfg_check_done),
   .sleep_mode(sleep_mode), .cfg_load_req(cfg_load_req), .cfg_check_req(cfg_check_req)
);

/* test/crp_host.sv */
// Purpose: Bus master model for crp_port
// Assumes: Line pulled up; sda_pull drives it low
// Notes:   Each level held 4 clocks; fcs runs over data bits
`timescale 1ns/100ps
module crp_host
(
   input  wire logic sys_clk,  // Clock
   input  wire logic sda,      // Resolved line
   output logic      scl,      // Bus clock
   output logic      sda_pull  // Pull line low
);
   logic [7:0] fcs;
   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
      fcs = 8'hFF;
   end
   task tick;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask
   task send_bit(input logic d, input logic f, output logic q);
      sda_pull = !d;
      tick;
      scl = 1'b1;
      tick;
      q = sda;
      if (f)
         fcs = {fcs[6:0], 1'b0} ^ ((fcs[7] ^ q) ? 8'hD5 : 8'h00);
      scl = 1'b0;
      tick;
   endtask
   // Start or repeated start
   task start(input logic first);
      if (first)
         fcs = 8'hFF;
      sda_pull = 1'b0;
      tick;
      scl = 1'b1;
      tick;
      sda_pull = 1'b1;
      tick;
      scl = 1'b0;
      tick;
   endtask
   task stop;
      sda_pull = 1'b1;
      tick;
      scl = 1'b1;
      tick;
      sda_pull = 1'b0;
      tick;
   endtask
   task wbyte(input logic [7:0] b, output logic ack);
      logic q;
      for (int i = 7; i >= 0; i--)
         send_bit(b[i], 1'b1, q);
      send_bit(1'b1, 1'b0, q);
      ack = !q;
   endtask
   task rbyte(input logic nack, output logic [7:0] b);
      logic q;
      for (int i = 7; i >= 0; i--)
         send_bit(1'b1, 1'b1, b[i]);
      send_bit(nack, 1'b0, q);
   endtask
endmodule

/* test/crp_port_tb.sv */
// Purpose: Self-checking bench for crp_port
// Assumes: crp_host drives the bus side
// Notes:   Each scenario task judges its own results
`timescale 1ns/100ps
module crp_port_tb;
   logic        sys_clk, rst_n, scl, sda, sda_pull, sda_out, sda_oe, sleep_mode;
   logic        cfg_load_done, cfg_check_done, cfg_load_req, cfg_check_req;
   logic [15:0] evt_set, lvl_in, temp_in, press_in;
   logic [7:0]  rdat [0:7];
   int          bad_count, samples_checked;
   assign sda = !(sda_pull || sda_oe);
   crp_port u_crp_port
   (
      .sys_clk(sys_clk), .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .evt_set(evt_set), .lvl_in(lvl_in), .temp_in(temp_in),
      .press_in(press_in), .cfg_load_done(cfg_load_done), .cfg_check_done(cfg_check_done),
      .sleep_mode(sleep_mode), .cfg_load_req(cfg_load_req), .cfg_check_req(cfg_check_req)
   );
   crp_host u_crp_host
   (
      .sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull)
   );
   function automatic logic [3:0] header_check_nibble_f(input logic [11:0] d);
      logic [3:0] c;
      c = 4'hF;
      for (int i = 11; i >= 0; i--)
         c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? 4'h3 : 4'h0);
      return c;
   endfunction
   task complete_run;
      if (bad_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wait_lvl(ref logic s, input logic v, input string name);
      for (int i = 0; i < 8 && s !== v; i++)
         @(posedge sys_clk) #1;
      cmp(name, {15'h0, v}, {15'h0, s});
      if (s !== v)
         complete_run;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(posedge sys_clk) #1;
      s = 1'b0;
   endtask
   task automatic hdr(input logic [7:0] mem, input logic [3:0] len, output logic ok);
      logic a0, a1, a2;
      u_crp_host.start(1'b1);
      u_crp_host.wbyte(8'hDA, a0);
      u_crp_host.wbyte(mem, a1);
      u_crp_host.wbyte({len, header_check_nibble_f({mem, len})}, a2);
      ok = a0 & a1 & a2;
   endtask
   task automatic wr(input logic [7:0] mem, input logic [15:0] w, output logic ok);
      logic a0, a1, a2;
      logic [7:0] ck;
      hdr(mem, 4'h1, ok);
      u_crp_host.wbyte(w[7:0], a0);
      u_crp_host.wbyte(w[15:8], a1);
      ck = u_crp_host.fcs;
      u_crp_host.wbyte(ck, a2);
      u_crp_host.stop;
      ok = ok & a0 & a1 & a2;
   endtask
   task automatic rd(input logic [7:0] mem, input logic [3:0] len);
      logic ok;
      logic [7:0] ck, exp;
      hdr(mem, len, ok);
      u_crp_host.start(1'b0);
      u_crp_host.wbyte(8'hDB, ok);
      for (int i = 0; i <= len; i++)
         u_crp_host.rbyte(1'b0, rdat[i]);
      exp = u_crp_host.fcs;
      u_crp_host.rbyte(1'b1, ck);
      u_crp_host.stop;
      cmp("read check byte", {8'h00, exp}, {8'h00, ck});
   endtask
   task t_addr;
      logic a;
      u_crp_host.start(1'b1);
      u_crp_host.wbyte(8'hD8, a);
      u_crp_host.stop;
      cmp("plain address ack", 16'h0000, {15'h0, a});
   endtask
   task t_read;
      lvl_in = 16'h001E;
      cmp("read header byte", 16'h005B, {8'h00, 4'h5, header_check_nibble_f({8'h2E, 4'h5})});
      rd(8'h2E, 4'h5);
      cmp("temperature", temp_in, {rdat[1], rdat[0]});
      cmp("pressure", press_in, {rdat[3], rdat[2]});
      cmp("status copy", 16'h001E, {rdat[5], rdat[4]});
   endtask
   task t_clear;
      logic ok;
      lvl_in = 16'h0000;
      cmp("write header nibble", 16'h0006, {12'h000, header_check_nibble_f({8'h36, 4'h1})});
      pulse_evt();
      wr(8'h36, 16'hCF9E, ok);
      cmp("clear write ack", 16'h0001, {15'h0, ok});
      rd(8'h36, 4'h1);
      cmp("status after clear", 16'h3061, {rdat[1], rdat[0]});
   endtask
   task pulse_evt();
      evt_set = 16'hFFFF;
      @(posedge sys_clk) #1;
      evt_set = 16'h0000;
   endtask
   task t_protect;
      logic ok;
      wr(8'h2E, 16'h1234, ok);
      cmp("protected write ack", 16'h0001, {15'h0, ok});
      rd(8'h2E, 4'h1);
      cmp("protected word", temp_in, {rdat[1], rdat[0]});
   endtask
   task t_badhdr;
      logic a0, a1, a2;
      u_crp_host.start(1'b1);
      u_crp_host.wbyte(8'hDA, a0);
      u_crp_host.wbyte(8'h36, a1);
      u_crp_host.wbyte({4'h1, header_check_nibble_f({8'h36, 4'h1}) ^ 4'h1}, a2);
      u_crp_host.stop;
      cmp("bad header ack", 16'h0000, {15'h0, a2});
      rd(8'h36, 4'h1);
      cmp("error event", 16'h3861, {rdat[1], rdat[0]});
   endtask
   task t_cmd;
      logic ok;
      wr(8'h22, 16'h6C32, ok);
      cmp("sleep", 16'h0001, {15'h0, sleep_mode});
      wr(8'h22, 16'h1234, ok);
      cmp("other code", 16'h0001, {15'h0, sleep_mode});
      rd(8'h22, 4'h1);
      cmp("command reads zero", 16'h0000, {rdat[1], rdat[0]});
      wr(8'h22, 16'hB169, ok);
      cmp("reset wakes", 16'h0000, {15'h0, sleep_mode});
      wait_lvl(cfg_load_req, 1'b1, "load step");
      pulse(cfg_load_done);
      wait_lvl(cfg_check_req, 1'b1, "check step");
      pulse(cfg_check_done);
      wait_lvl(cfg_check_req, 1'b0, "check end");
      rd(8'h36, 4'h1);
      cmp("status reloaded", 16'h0000, {rdat[1], rdat[0]});
   endtask
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = !sys_clk;
   end
   initial
   begin
      rst_n = 1'b0;
      evt_set = 16'h0000;
      lvl_in = 16'h0000;
      temp_in = 16'h7DF2;
      press_in = 16'h82EA;
      cfg_load_done = 1'b0;
      cfg_check_done = 1'b0;
      bad_count = 0;
      samples_checked = 0;
      repeat (8) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge sys_clk) #1;
      t_addr;
      t_read;
      t_clear;
      t_protect;
      t_badhdr;
      t_cmd;
      complete_run;
   end
   initial
   begin
      repeat (90000) @(posedge sys_clk);
      bad_count++;
      complete_run;
   end
endmodule
